// >>> ebcs_pkg.sv
// package of constants for the external bus cycle strobe block
package ebcs_pkg;
    // reset values of the strobes
    localparam logic ALE_RESET      = 1'b0;
    localparam logic UBE_N_RESET    = 1'b1;
    // default cycle length in clocks, address phase length in clocks
    localparam int   CYCLE_CLKS_DEF = 4;
    localparam int   ADDR_CLKS_DEF  = 1;
    localparam int   ADDR_WIDTH_DEF = 16;
    localparam int   DATA_WIDTH_DEF = 16;
    // byte lane codes: {upper byte enable low, address bit 0}
    localparam logic [1:0] LANE_BOTH = 2'h0;
    localparam logic [1:0] LANE_HIGH = 2'h1;
    localparam logic [1:0] LANE_LOW  = 2'h2;
    // cycle sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h4
    } ebcs_state_e;
endpackage

// >>> ebcs_lane_decode.sv
// byte lane decoder for the upper byte enable
`timescale 1ns/1ps
`default_nettype none
module ebcs_lane_decode (
    input  wire logic wideBus,
    input  wire logic isWord,
    input  wire logic addrBit0,
    output logic      upperByteEnableN
);
    // enable the upper lane for word or odd-byte access on a 16-bit bus
    always_comb
    begin
        upperByteEnableN = 1'b1;
        if (wideBus && (isWord || addrBit0))
            upperByteEnableN = 1'b0;
    end
endmodule
`default_nettype wire

// >>> ebcs_strobes.sv
// address latch strobe and upper byte enable generator for external cycles
// Overview of operation
// - address latch strobe is high only during an external memory cycle
// - strobe asserts at cycle start while valid address is on the bus
// - on 16-bit cycles upper enable goes low for word and high-byte access
// - low upper enable means upper data half valid; paired with address bit 0
// - enable/bit0: 0/0 both bytes, 0/1 high only, 1/0 low only
`timescale 1ns/1ps
`default_nettype none
module ebcs_strobes #(
    parameter int CYCLE_CLKS = ebcs_pkg::CYCLE_CLKS_DEF,
    parameter int ADDR_CLKS  = ebcs_pkg::ADDR_CLKS_DEF,
    parameter int ADDR_WIDTH = ebcs_pkg::ADDR_WIDTH_DEF
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  cycleReq,
    input  wire logic [ADDR_WIDTH-1:0] cycleAddr,
    input  wire logic                  cycleWord,
    input  wire logic                  cycleWide,
    input  wire logic                  cycleWrite,
    output logic                       cycleReady,
    output logic                       cycleDone,
    output logic                       addrLatchStrobe,
    output logic                       upper_byte_enable_n,
    output logic                       addrPhase,
    output logic [ADDR_WIDTH-1:0]      busAddr,
    output logic                       busWrite,
    output logic                       busActive
);
    // parameter checks: the cycle counter is eight bits and a data phase must follow
    if (CYCLE_CLKS < ADDR_CLKS + 1 || ADDR_CLKS < 1 || CYCLE_CLKS > 255)
    begin : g_bad_cycle
        $error("ebcs_strobes: cycle must exceed address phase");
    end
    if (ADDR_WIDTH < 1)
    begin : g_bad_width
        $error("ebcs_strobes: address width too small");
    end

    ebcs_pkg::ebcs_state_e stateQ;
    ebcs_pkg::ebcs_state_e stateD;
    logic [7:0]            cntQ;
    logic                  lastAddr;
    logic                  lastData;
    logic                  ubeN;
    logic                  startCycle;
    // edges from the taking edge to the edge that samples the done pulse
    localparam int DONE_DELAY = CYCLE_CLKS + 1;

    assign startCycle = cycleReq && (stateQ == ebcs_pkg::ST_IDLE);
    assign cycleReady = (stateQ == ebcs_pkg::ST_IDLE);
    assign lastAddr   = (cntQ == 8'(ADDR_CLKS - 1));
    assign lastData   = (cntQ == 8'(CYCLE_CLKS - 1));

    // cycle sequencer: idle, address phase, data phase
    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            ebcs_pkg::ST_IDLE: if (cycleReq) stateD = ebcs_pkg::ST_ADDR;
            ebcs_pkg::ST_ADDR: if (lastAddr) stateD = ebcs_pkg::ST_DATA;
            ebcs_pkg::ST_DATA: if (lastData) stateD = ebcs_pkg::ST_IDLE;
            default:           stateD = ebcs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stateQ <= ebcs_pkg::ST_IDLE;
        else
            stateQ <= stateD;
    end

    // clocks spent in the current cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n || stateQ == ebcs_pkg::ST_IDLE)
            cntQ <= 8'h00;
        else
            cntQ <= cntQ + 8'h01;
    end

    // address and direction captured at cycle start and held
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busAddr  <= '0;
            busWrite <= 1'b0;
        end
        else if (startCycle)
        begin
            busAddr  <= cycleAddr;
            busWrite <= cycleWrite;
        end
    end

    ebcs_lane_decode u_lane (
        .wideBus          (cycleWide),
        .isWord           (cycleWord),
        .addrBit0         (cycleAddr[0]),
        .upperByteEnableN (ubeN)
    );

    // strobe follows the address phase; lane enable held over the whole cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            addrLatchStrobe     <= ebcs_pkg::ALE_RESET;
            upper_byte_enable_n <= ebcs_pkg::UBE_N_RESET;
            addrPhase           <= 1'b0;
            busActive           <= 1'b0;
            cycleDone           <= 1'b0;
        end
        else
        begin
            addrLatchStrobe <= (stateD == ebcs_pkg::ST_ADDR);
            addrPhase       <= (stateD == ebcs_pkg::ST_ADDR);
            busActive       <= (stateD != ebcs_pkg::ST_IDLE);
            cycleDone       <= (stateQ == ebcs_pkg::ST_DATA) && lastData;
            if (startCycle)
                upper_byte_enable_n <= ubeN;
            else if (stateD == ebcs_pkg::ST_IDLE)
                upper_byte_enable_n <= ebcs_pkg::UBE_N_RESET;
        end
    end

    // protocol checks for the strobe, the lane enable and the cycle framing
    sequence s_start;
        cycleReq && cycleReady;
    endsequence

    sequence s_addrPhase;
        addrLatchStrobe [*1];
    endsequence

    a_strobe_in_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        addrLatchStrobe |-> busActive)
        else $error("strobe high outside an external cycle");

    a_strobe_at_start: assert property (@(posedge clk) disable iff (!rst_n)
        s_start |=> s_addrPhase ##0 (busAddr == $past(cycleAddr)))
        else $error("strobe not raised with captured address");

    a_addr_held_latch: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(addrLatchStrobe) && $past(rst_n) |-> busActive && $stable(busAddr))
        else $error("address moved at strobe fall");

    a_ube_word_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_start ##0 (cycleWide && cycleWord) |=> !upper_byte_enable_n)
        else $error("upper enable not low for word access");

    a_ube_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        !busActive |-> upper_byte_enable_n)
        else $error("upper enable low with no cycle");

    a_lane_low_only: assert property (@(posedge clk) disable iff (!rst_n)
        s_start ##0 (!cycleWord && !cycleAddr[0]) |=> upper_byte_enable_n)
        else $error("upper enable low for low-byte access");

    a_lane_high_only: assert property (@(posedge clk) disable iff (!rst_n)
        s_start ##0 (cycleWide && !cycleWord && cycleAddr[0]) |=> !upper_byte_enable_n)
        else $error("upper enable high for high-byte access");

    a_cycle_length: assert property (@(posedge clk) disable iff (!rst_n)
        s_start |-> ##[1:300] cycleDone)
        else $error("external cycle never finished");

    // done pulse lands a fixed number of edges after the request is taken
    a_done_timing: assert property (@(posedge clk) disable iff (!rst_n)
        s_start |-> ##DONE_DELAY cycleDone)
        else $error("done pulse at the wrong edge");

    // done is a single-clock pulse
    a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        cycleDone |=> !cycleDone)
        else $error("done pulse longer than one clock");

    // no new request is taken while a cycle is on the bus
    a_ready_when_busy: assert property (@(posedge clk) disable iff (!rst_n)
        busActive |-> !cycleReady)
        else $error("ready high during an external cycle");

    // the cycle is over once done shows
    a_done_ready: assert property (@(posedge clk) disable iff (!rst_n)
        cycleDone |-> cycleReady && !busActive)
        else $error("bus still active with done high");

    // outputs sit at their idle levels right after reset
    a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> !addrLatchStrobe && upper_byte_enable_n && !busActive && !cycleDone)
        else $error("strobes not idle after reset");

    // address phase flag mirrors the strobe
    a_phase_mirror: assert property (@(posedge clk) disable iff (!rst_n)
        addrPhase == addrLatchStrobe)
        else $error("address phase flag differs from strobe");

    // strobe only rises on the edge after a cycle start
    a_strobe_rise_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(addrLatchStrobe) |-> $past(startCycle))
        else $error("strobe rose without a cycle start");

    // address and direction stay put for the whole cycle
    a_bus_held_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        busActive && $past(busActive) |-> $stable(busAddr) && $stable(busWrite))
        else $error("address or direction moved inside a cycle");

    // eight-bit cycles never enable the upper lane
    a_ube_narrow_high: assert property (@(posedge clk) disable iff (!rst_n)
        s_start ##0 !cycleWide |=> upper_byte_enable_n)
        else $error("upper enable low on an eight-bit cycle");

    // lane enable is steady while the data may be moving
    a_ube_held_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        busActive && $past(busActive) |-> $stable(upper_byte_enable_n))
        else $error("upper enable changed inside a cycle");
endmodule
`default_nettype wire

// >>> ebcs_ext_mem.sv
// external address latch and byte lane picker facing the strobes
`timescale 1ns/1ps
`default_nettype none
module ebcs_ext_mem (
    input  wire logic        addrLatchStrobe,
    input  wire logic [15:0] busAddr,
    input  wire logic        upper_byte_enable_n,
    output logic      [15:0] latchedAddr,
    output logic      [1:0]  laneCode
);
    // latch closes on the falling strobe and keeps all 16 address bits
    always @(negedge addrLatchStrobe)
        latchedAddr <= busAddr;
    // byte lane picked from upper enable and address bit 0
    assign laneCode = {upper_byte_enable_n, busAddr[0]};
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the external bus cycle strobes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [15:0] a; logic w; logic wd; logic wr;
                           logic [1:0] lane;} ebcs_row_s;
    logic        clk, rst_n, cycleReq, cycleWord, cycleWide, cycleWrite;
    logic        cycleReady, cycleDone, strobe, ubeN, addrPhase, busWrite, busActive;
    logic [15:0] cycleAddr, busAddr, latchedAddr;
    logic [1:0]  laneCode;
    int          fail_count = 0;
    int          checks = 0;
    int          n = 0;
    // rows: address, word, wide bus, write, expected lane code
    ebcs_row_s   rows [5] = '{{16'h1234, 1'b1, 1'b1, 1'b1, 2'h0},
                             {16'h00F1, 1'b0, 1'b1, 1'b0, 2'h1},
                             {16'hFFFE, 1'b0, 1'b1, 1'b1, 2'h2},
                             {16'h1000, 1'b1, 1'b0, 1'b0, 2'h2},
                             {16'h8001, 1'b0, 1'b0, 1'b1, 2'h3}};
    ebcs_strobes #(.CYCLE_CLKS(4), .ADDR_CLKS(1), .ADDR_WIDTH(16)) uut (
        .clk(clk), .rst_n(rst_n), .cycleReq(cycleReq), .cycleAddr(cycleAddr),
        .cycleWord(cycleWord), .cycleWide(cycleWide), .cycleWrite(cycleWrite),
        .cycleReady(cycleReady), .cycleDone(cycleDone), .addrLatchStrobe(strobe),
        .upper_byte_enable_n(ubeN), .addrPhase(addrPhase), .busAddr(busAddr),
        .busWrite(busWrite), .busActive(busActive));
    ebcs_ext_mem ext (.addrLatchStrobe(strobe), .busAddr(busAddr),
        .upper_byte_enable_n(ubeN), .latchedAddr(latchedAddr), .laneCode(laneCode));
    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare one value and count it
    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // print counts and verdict, then stop
    task automatic final_report();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one whole external cycle, walked edge by edge
    task automatic run(input ebcs_row_s r);
        cycleAddr = r.a;
        cycleWord = r.w;
        cycleWide = r.wd;
        cycleWrite = r.wr;
        cycleReq = 1'b1;
        @(posedge clk) #1;
        cycleReq = 1'b0;
        cmp("strobe", 1'b1, strobe);
        cmp("phase", 1'b1, addrPhase);
        cmp("addr", r.a, busAddr);
        cmp("write", r.wr, busWrite);
        cmp("ready", 1'b0, cycleReady);
        cmp("ube", r.lane[1], ubeN);
        cmp("lane", r.lane, laneCode);
        @(posedge clk) #1;
        cmp("strobe", 1'b0, strobe);
        cmp("latch", r.a, latchedAddr);
        cmp("active", 1'b1, busActive);
        repeat (2) @(posedge clk) #1;
        cmp("ubehold", r.lane[1], ubeN);
        cmp("early", 1'b0, cycleDone);
        @(posedge clk) #1;
        cmp("done", 1'b1, cycleDone);
        cmp("ubeidle", 1'b1, ubeN);
        cmp("ready", 1'b1, cycleReady);
    endtask
    // hang guard
    initial
    begin
        #20000;
        fail_count++;
        final_report();
    end
    // main sequence
    initial
    begin
        {rst_n, cycleReq, cycleWord, cycleWide, cycleWrite, cycleAddr} = '0;
        repeat (2) @(posedge clk) #1;
        rst_n = 1'b1;
        foreach (rows[i])
            run(rows[i]);
        // request held high: busy cycles refuse it, so two strobes in ten clocks
        cycleReq = 1'b1;
        repeat (10) @(posedge clk) #1 n += strobe;
        cmp("burst", 16'(n), 16'h2);
        // start one more word cycle, then reset in its address phase
        cycleWord = 1'b1;
        cycleWide = 1'b1;
        @(posedge clk) #1;
        cmp("midstrobe", 1'b1, strobe);
        cmp("midube", 1'b0, ubeN);
        rst_n = 1'b0;
        @(posedge clk) #1;
        cmp("rststrobe", 1'b0, strobe);
        cmp("rstube", 1'b1, ubeN);
        cmp("rstaddr", 16'h0000, busAddr);
        cycleReq = 1'b0;
        rst_n = 1'b1;
        @(posedge clk) #1;
        cmp("active", 1'b0, busActive);
        cmp("rstready", 1'b1, cycleReady);
        cmp("rstdone", 1'b0, cycleDone);
        final_report();
    end
endmodule
`default_nettype wire
